// *** logic/decoder_misc_gain_status_regs.sv ***
// Register slice: misc/gate control, raw gain and offset, status byte one,
// plus the raw-path arithmetic, field counter and vertical gate they steer.
// Assumes a serial-bus front end delivers byte writes and read strobes on
// i_clk_sys, and decoder status inputs come from other clock domains.
`include "decoder_regs_consts.svh"
`default_nettype none
module decoder_misc_gain_status_regs
  import decoder_regs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_horiz_unlocked,
  input wire logic i_slow_constant,
  input wire logic i_gain_max_clamp,
  input wire logic i_gain_min_clamp,
  input wire logic i_white_peak_active,
  input wire logic [1:0] i_detected_colour_std,
  input wire logic i_field_start,
  input wire logic i_field_two,
  input wire logic [8:0] i_line_num,
  input wire logic [7:0] i_gate_start_lsb,
  input wire logic [7:0] i_gate_stop_lsb,
  input wire logic i_raw_valid,
  input wire logic [7:0] i_raw_data,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_pixel_clk_out_en,
  output logic o_half_pixel_clk_out_en,
  output logic [2:0] o_search_latency,
  output logic o_search_done,
  output logic o_vertical_gate,
  output logic o_raw_valid,
  output logic [7:0] o_raw_data
);
  // Register file and read port
  logic [7:0] misc_q, misc_d;
  logic [7:0] gain_q, gain_d;
  logic [7:0] offs_q, offs_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [7:0] status_byte;

  // Status synchroniser
  logic [6:0] stat_in;
  wire logic [6:0] stat_sync;
  colour_std_type colour_std;

  // Standard search
  logic [2:0] field_cnt_q, field_cnt_d;
  logic [2:0] field_next;
  logic done_q, done_d;
  logic [2:0] latency;

  // Vertical gate
  gate_state_type gate_q, gate_d;
  logic gate_out_q, gate_out_d;
  logic alt_gate;
  logic [8:0] start_line, stop_line;

  // Raw path
  logic [7:0] raw_q, raw_d;
  logic raw_valid_q, raw_valid_d;
  logic [15:0] product;
  logic [8:0] scaled;
  logic [10:0] sum;

  assign latency = misc_q[`POS_LATENCY_LSB +: 3];
  assign alt_gate = misc_q[`POS_ALT_GATE];
  assign colour_std = colour_std_type'(stat_sync[1:0]);

  // Status levels cross from decoder clocks: two flip-flops per bit
  assign stat_in = {i_horiz_unlocked, i_slow_constant, i_gain_max_clamp,
    i_gain_min_clamp, i_white_peak_active, i_detected_colour_std};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      logic meta_q, meta_d;
      logic sync_q, sync_d;

      // Only the second stage reads the first
      always_comb
      begin
        meta_d = stat_in[gi];
        sync_d = meta_q;
      end

      always_ff @(posedge i_clk_sys)
      begin
        if (i_rst)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else if (i_ce)
        begin
          meta_q <= meta_d;
          sync_q <= sync_d;
        end
      end

      assign stat_sync[gi] = sync_q;
    end
  endgenerate

  // Bit 7 is undefined and reads 0
  assign status_byte = {1'b0, stat_sync[`POS_HORIZ_UNLOCKED],
    stat_sync[`POS_SLOW_CONSTANT], stat_sync[`POS_GAIN_MAX],
    stat_sync[`POS_GAIN_MIN], stat_sync[`POS_WHITE_PEAK],
    colour_std};

  // Register writes; status byte one has no write path
  always_comb
  begin
    misc_d = misc_q;
    gain_d = gain_q;
    offs_d = offs_q;
    if (i_wr_en)
    begin
      case (i_addr)
        `ADDR_MISC_GATE: misc_d = i_wdata;
        `ADDR_RAW_GAIN: gain_d = i_wdata;
        `ADDR_RAW_OFFSET: offs_d = i_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      misc_q <= `MISC_GATE_RESET;
      gain_q <= `RAW_GAIN_RESET;
      offs_q <= `RAW_OFFSET_RESET;
    end
    else if (i_ce)
    begin
      misc_q <= misc_d;
      gain_q <= gain_d;
      offs_q <= offs_d;
    end
  end

  // Reads see the registers before a same-cycle write lands
  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (i_rd_en)
    begin
      rvalid_d = 1'b1;
      case (i_addr)
        `ADDR_MISC_GATE: rdata_d = misc_q;
        `ADDR_RAW_GAIN: rdata_d = gain_q;
        `ADDR_RAW_OFFSET: rdata_d = offs_q;
        `ADDR_STATUS_ONE: rdata_d = status_byte;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (i_ce)
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Standard search: done after latency fields counted
  always_comb
  begin
    field_cnt_d = field_cnt_q;
    done_d = done_q;
    field_next = field_cnt_q + 3'h1;
    // Latency 000 is reserved: the search never completes
    if (i_field_start && latency != `LATENCY_RESERVED)
    begin
      if (field_next >= latency)
      begin
        field_cnt_d = 3'h0;
        done_d = 1'b1;
      end
      else
      begin
        field_cnt_d = field_next;
        done_d = 1'b0;
      end
    end
    else if (i_field_start)
      done_d = 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      field_cnt_q <= 3'h0;
      done_q <= 1'b0;
    end
    else if (i_ce)
    begin
      field_cnt_q <= field_cnt_d;
      done_q <= done_d;
    end
  end

  // Vertical gate window with field 2 shift
  always_comb
  begin
    start_line = {misc_q[`POS_START_MSB], i_gate_start_lsb};
    stop_line = {misc_q[`POS_STOP_MSB], i_gate_stop_lsb};
    // Field 2 shift: a start line of 0 wraps to line 511
    if (alt_gate && i_field_two)
    begin
      start_line = start_line - 9'h001;
      stop_line = stop_line - 9'h001;
    end
    gate_d = gate_q;
    case (gate_q)
      gate_idle:
        if (i_line_num == start_line)
          gate_d = gate_open;
      gate_open:
        if (i_line_num == stop_line)
          gate_d = gate_idle;
      default: gate_d = gate_idle;
    endcase
    gate_out_d = (gate_d == gate_open);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      gate_q <= gate_idle;
      gate_out_q <= 1'b0;
    end
    else if (i_ce)
    begin
      gate_q <= gate_d;
      gate_out_q <= gate_out_d;
    end
  end

  // Raw path: gain/128 then offset minus 128, saturated to 8 bits
  always_comb
  begin
    product = {8'h00, i_raw_data} * {8'h00, gain_q};
    scaled = product[15:7];
    sum = {2'b00, scaled} + {3'b000, offs_q} - {2'b00, `OFFSET_ZERO};
    raw_d = sum[7:0];
    if (sum[10])
      raw_d = 8'h00;
    else if (sum[9:8] != 2'b00)
      raw_d = 8'hff;
    raw_valid_d = i_raw_valid;
    // Gain code zero switches the raw output off
    if (gain_q == 8'h00)
    begin
      raw_d = 8'h00;
      raw_valid_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      raw_q <= 8'h00;
      raw_valid_q <= 1'b0;
    end
    else if (i_ce)
    begin
      raw_q <= raw_d;
      raw_valid_q <= raw_valid_d;
    end
  end

  // Every output is a register bit
  assign o_rdata = rdata_q;
  assign o_rdata_valid = rvalid_q;
  assign o_pixel_clk_out_en = misc_q[`POS_CLK_OUT_EN];
  assign o_half_pixel_clk_out_en = misc_q[`POS_HALF_CLK_OUT_EN];
  assign o_search_latency = latency;
  assign o_search_done = done_q;
  assign o_vertical_gate = gate_out_q;
  assign o_raw_valid = raw_valid_q;
  assign o_raw_data = raw_q;
endmodule // decoder_misc_gain_status_regs
`default_nettype wire

// *** logic/decoder_regs_consts.svh ***
// Offsets, field positions, reset values and codes for the decoder
// misc/gain/status register slice. Included by the core.
`ifndef DECODER_REGS_CONSTS_SVH
`define DECODER_REGS_CONSTS_SVH
`define ADDR_MISC_GATE 8'h17
`define ADDR_RAW_GAIN 8'h18
`define ADDR_RAW_OFFSET 8'h19
`define ADDR_STATUS_ONE 8'h1e
`define MISC_GATE_RESET 8'h00
`define RAW_GAIN_RESET 8'h80
`define RAW_OFFSET_RESET 8'h80
`define POS_CLK_OUT_EN 7
`define POS_HALF_CLK_OUT_EN 6
`define POS_LATENCY_LSB 3
`define POS_ALT_GATE 2
`define POS_STOP_MSB 1
`define POS_START_MSB 0
`define POS_HORIZ_UNLOCKED 6
`define POS_SLOW_CONSTANT 5
`define POS_GAIN_MAX 4
`define POS_GAIN_MIN 3
`define POS_WHITE_PEAK 2
`define NOMINAL_GAIN 8'h80
`define OFFSET_ZERO 9'h080
`define LATENCY_RESERVED 3'h0
`endif

// *** logic/decoder_regs_pkg.sv ***
// Types shared by the decoder register slice.
// Assumes the constants header sits beside it on the include path.
`default_nettype none
package decoder_regs_pkg;
  typedef enum logic [1:0] {
    std_none,
    std_ntsc,
    std_pal,
    std_secam
  } colour_std_type;
  typedef enum logic [1:0] {
    gate_idle,
    gate_open
  } gate_state_type;
endpackage
`default_nettype wire

// *** tb/decoder_misc_gain_status_regs_bench.sv ***
// Bench for the misc, raw gain/offset and status register slice.
// Drives strobes and decoder inputs directly on falling edges.
`default_nettype none
module decoder_misc_gain_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, ce = 1, we = 0, re = 0, fs = 0, f2 = 0, rv = 0;
  logic vld, rvo, gt, dn, pe, he;
  logic [7:0] a = 0, wd = 0, ri = 0, gs = 8'h0a, ge = 8'h14, rq, ro;
  logic [6:0] st = 0;
  logic [8:0] ln = 0;
  logic [2:0] lat;
  logic [1:0] c;
  int error_cnt = 0, compares = 0;
  always #10 clk = ~clk;
  decoder_misc_gain_status_regs dut (.i_clk_sys(clk), .i_rst(rst),
    .i_ce(ce), .i_wr_en(we), .i_rd_en(re), .i_addr(a), .i_wdata(wd),
    .i_horiz_unlocked(st[6]), .i_slow_constant(st[5]),
    .i_gain_max_clamp(st[4]), .i_gain_min_clamp(st[3]),
    .i_white_peak_active(st[2]), .i_detected_colour_std(st[1:0]),
    .i_field_start(fs), .i_field_two(f2), .i_line_num(ln),
    .i_gate_start_lsb(gs), .i_gate_stop_lsb(ge), .i_raw_valid(rv),
    .i_raw_data(ri), .o_rdata(rq), .o_rdata_valid(vld),
    .o_pixel_clk_out_en(pe), .o_half_pixel_clk_out_en(he),
    .o_search_latency(lat), .o_search_done(dn), .o_vertical_gate(gt),
    .o_raw_valid(rvo), .o_raw_data(ro));
  task automatic close_out;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [8:0] v, logic [8:0] e);
    compares++;
    if (v !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    a = ad;
    wd = d;
    we = 1;
    @(negedge clk);
    we = 0;
    @(negedge clk);
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    a = ad;
    re = 1;
    @(negedge clk);
    re = 0;
    for (int i = 0; i < 3 && vld !== 1'b1; i++)
      @(negedge clk);
    if (vld !== 1'b1)
    begin
      error_cnt++;
      close_out();
    end
    chk("rdata", rq, e);
    @(negedge clk);
  endtask
  task automatic raw(logic [7:0] d, logic v, logic [7:0] e);
    ri = d;
    rv = 1;
    @(negedge clk);
    rv = 0;
    chk("raw_valid", rvo, v);
    chk("raw_data", ro, e);
    @(negedge clk);
  endtask
  task automatic fld(int n, int l);
    for (int i = 1; i <= n; i++)
    begin
      fs = 1;
      @(negedge clk);
      fs = 0;
      @(negedge clk);
      chk("done", dn, l != 0 && i % l == 0);
    end
  endtask
  task automatic gate(logic alt, logic f);
    wr(8'h17, {5'b00011, alt, 2'b00});
    f2 = f;
    for (int l = 8; l < 23; l++)
    begin
      ln = l;
      @(negedge clk);
      chk("gate", gt, l >= 10 - (alt & f) && l < 20 - (alt & f));
    end
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 0;
    rd(8'h18, 8'h80);
    rd(8'h19, 8'h80);
    rd(8'h33, 8'h00);
    wr(8'h17, 8'hc0);
    chk("clk_en", {pe, he}, 2'b11);
    rd(8'h17, 8'hc0);
    for (int k = 0; k < 4; k++)
    begin
      c = k[1:0];
      st = {c, ~c, c[0], c};
      repeat (4) @(negedge clk);
      rd(8'h1e, {1'b0, st});
    end
    wr(8'h1e, 8'hff);
    rd(8'h1e, {1'b0, st});
    wr(8'h18, 8'hff);
    raw(8'h40, 1, 8'h7f);
    wr(8'h18, 8'h80);
    wr(8'h19, 8'h00);
    raw(8'h10, 1, 8'h00);
    wr(8'h19, 8'hff);
    raw(8'h20, 1, 8'h9f);
    raw(8'hf0, 1, 8'hff);
    wr(8'h18, 8'h00);
    raw(8'h55, 0, 8'h00);
    ce = 0;
    wr(8'h19, 8'h00);
    ce = 1;
    rd(8'h19, 8'hff);
    wr(8'h17, 8'h18);
    chk("latency", lat, 9'h003);
    fld(6, 3);
    wr(8'h17, 8'h38);
    fld(7, 7);
    wr(8'h17, 8'h00);
    fld(2, 0);
    gate(0, 1);
    gate(1, 0);
    gate(1, 1);
    close_out();
  end
endmodule // decoder_misc_gain_status_regs_bench
`default_nettype wire

// *** tb/decoder_regs_asserts.sv ***
// Checker for the misc, raw gain/offset and status register slice.
// Bound to the slice; sees only its ports, one clock domain.
`default_nettype none
module decoder_regs_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_horiz_unlocked,
  input wire logic i_slow_constant,
  input wire logic i_gain_max_clamp,
  input wire logic i_gain_min_clamp,
  input wire logic i_white_peak_active,
  input wire logic [1:0] i_detected_colour_std,
  input wire logic i_field_start,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_valid,
  input wire logic o_pixel_clk_out_en,
  input wire logic o_half_pixel_clk_out_en,
  input wire logic [2:0] o_search_latency,
  input wire logic o_search_done
);
  wire logic [6:0] s = {i_horiz_unlocked, i_slow_constant,
    i_gain_max_clamp, i_gain_min_clamp, i_white_peak_active,
    i_detected_colour_std};
  wire logic rd = i_ce && i_rd_en;
  wire logic wr = i_ce && i_wr_en;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_valid; rd |=> o_rdata_valid; endproperty
  property p_stand; !rd |=> $stable(o_rdata); endproperty
  property p_bit7; rd && i_addr == 8'h1e |=> !o_rdata[7]; endproperty
  property p_stat;
    rd && i_addr == 8'h1e && s == $past(s, 2)
      && $past(i_ce) && $past(i_ce, 2)
      |=> o_rdata[6:0] == $past(s);
  endproperty
  property p_unmap;
    rd && !(i_addr inside {8'h17, 8'h18, 8'h19, 8'h1e})
      |=> o_rdata == 8'h00;
  endproperty
  property p_rw;
    wr && i_addr inside {8'h17, 8'h18, 8'h19} ##2
      rd && i_addr == $past(i_addr, 2) |=> o_rdata == $past(i_wdata, 3);
  endproperty
  property p_lat;
    wr && i_addr == 8'h17 |=> {o_pixel_clk_out_en,
      o_half_pixel_clk_out_en, o_search_latency} == $past(i_wdata[7:3]);
  endproperty
  property p_lat0;
    o_search_latency == 3'h0 && i_ce && i_field_start |=> !o_search_done;
  endproperty
  a_valid: assert property (p_valid) else $error("no read valid");
  a_stand: assert property (p_stand) else $error("read data moved");
  a_bit7: assert property (p_bit7) else $error("status bit 7 set");
  a_stat: assert property (p_stat) else $error("status bad");
  a_unmap: assert property (p_unmap) else $error("unmapped not 0");
  a_rw: assert property (p_rw) else $error("readback bad");
  a_lat: assert property (p_lat) else $error("misc outputs bad");
  a_lat0: assert property (p_lat0) else $error("done at lat 0");
  c_stat: cover property (rd && i_addr == 8'h1e);
  c_done: cover property (o_search_done);
  c_gain: cover property (wr && i_addr == 8'h18);
endmodule // decoder_regs_asserts
bind decoder_misc_gain_status_regs decoder_regs_asserts chk (.*);
`default_nettype wire
